// >>> pkg/ahs_pkg.sv
// Purpose: constants and types shared by the axis homing sequencer
// Assumes: 20 MHz clk, word-addressed Avalon-MM register slave
// Notes: register offsets are word indices; byte address is four times
//
// Behaviour
// - method 1: start moving toward minimum when negative limit inactive
// - method 1: home is first index moving right after negative limit clears
// - method 2: start moving toward maximum when positive limit inactive
// - method 2: home is first index moving left after positive limit clears
// - methods 3 to 6: start direction from home switch level at start
// - methods 3 to 6: home is index on chosen side of switch change
// - reversal may happen anywhere after a home switch change
// - methods 7 to 14: home switch is a zone; both its edges are seen
// - methods 7 to 10: start toward maximum unless switch already active
// - methods 11 to 14: start toward minimum unless switch already active
// - switch active at start: direction follows the sought edge
// - methods 7 to 14: home is index beside chosen switch edge
// - travel away from switch reverses at that side's limit switch
// - codes 15 and 16 are reserved and run no sequence
// - exactly four trigger inputs: two limits, home switch, index pulse
// - position count rises toward the maximum end
// - home offset shifts user zero relative to detected home
// - only outputs besides the Avalon-MM bus: homing status bits and velocity demand
// - control bit 8 stops the axis per halt option code
// - status bits 12 and 10 report progress, attained and completed
package ahs_pkg;
  // register word indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_METHOD = 4'h1;
  localparam logic [3:0] REG_SPD_SWITCH = 4'h2;
  localparam logic [3:0] REG_SPD_INDEX = 4'h3;
  localparam logic [3:0] REG_ACCEL = 4'h4;
  localparam logic [3:0] REG_OFFSET = 4'h5;
  localparam logic [3:0] REG_HALT_OPT = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_POSITION = 4'h8;
  localparam logic [3:0] REG_VELOCITY = 4'h9;
  // control and status bit positions
  localparam int CW_START_BIT = 4;
  localparam int CW_HALT_BIT = 8;
  localparam int SW_REACHED_BIT = 10;
  localparam int SW_ATTAINED_BIT = 12;
  localparam int SW_ERROR_BIT = 13;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] METHOD_RST = 8'h00;
  localparam logic [14:0] SPD_SWITCH_RST = 15'h0100;
  localparam logic [14:0] SPD_INDEX_RST = 15'h0010;
  localparam logic [14:0] ACCEL_RST = 15'h0010;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [2:0] HALT_OPT_RST = 3'h1;
  localparam logic [2:0] HALT_OPT_RAMP = 3'h1;
  // velocity ramp update period
  localparam int CLK_PERIOD_NS = 50;
  localparam int RAMP_PERIOD_NS = 10000;
  localparam int RAMP_CYCLES = RAMP_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_LAST = 8'(RAMP_CYCLES - 1);
  // synchronised input positions
  localparam int IN_W = 6;
  localparam int IN_NEG = 0;
  localparam int IN_POS = 1;
  localparam int IN_HOME = 2;
  localparam int IN_INDEX = 3;
  localparam int IN_STEP = 4;
  localparam int IN_UP = 5;
  // trigger select, equal to the input position
  localparam logic [1:0] TRIG_NEG = 2'h0;
  localparam logic [1:0] TRIG_POS = 2'h1;
  localparam logic [1:0] TRIG_HOME = 2'h2;

  typedef struct packed {
    logic valid;
    logic [1:0] trig;
    logic edge_b;
    logic final_right;
    logic low_right;
    logic high_right;
    logic lim_rev_en;
  } ahs_mcfg_t;
endpackage

// >>> pkg/ahs_trig_if.sv
// Purpose: synchronised trigger levels and edges between homing blocks
// Assumes: one clock domain
// Notes: rise and fall are one-cycle pulses
`timescale 1ns/100ps
interface ahs_trig_if;
  logic [ahs_pkg::IN_W-1:0] lvl;
  logic [ahs_pkg::IN_W-1:0] rise;
  logic [ahs_pkg::IN_W-1:0] fall;
  modport sync (output lvl, output rise, output fall);
  modport seq (input lvl, input rise, input fall);
  modport cnt (input lvl, input rise);
endinterface

// >>> verilog/ahs_input_sync.sv
// Purpose: two-flop synchroniser and edge detector for switch inputs
// Assumes: raw inputs may change at any time
// Notes: edges are taken from the second stage only
`timescale 1ns/100ps
module ahs_input_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ahs_pkg::IN_W-1:0] raw_in,
  ahs_trig_if.sync trig
);
  logic [ahs_pkg::IN_W-1:0] meta;
  logic [ahs_pkg::IN_W-1:0] stable;
  logic [ahs_pkg::IN_W-1:0] prev;

  // meta feeds stable only; prev gives the edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= raw_in;
      stable <= meta;
      prev <= stable;
    end
  end

  // level and one-cycle edge pulses
  assign trig.lvl = stable;
  assign trig.rise = stable & ~prev;
  assign trig.fall = ~stable & prev;
endmodule

// >>> verilog/ahs_pos_counter.sv
// Purpose: axis position counter with home offset preload
// Assumes: one synchronised step edge per encoder count
// Notes: a load in the same cycle as a step wins
`timescale 1ns/100ps
module ahs_pos_counter (
  input wire logic clk,
  input wire logic resetn,
  ahs_trig_if.cnt trig,
  input wire logic load,
  input wire logic [31:0] load_value,
  output logic [31:0] position
);
  // count up toward maximum, preload at home
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      position <= '0;
    end else if (load) begin
      position <= load_value;
    end else if (trig.rise[ahs_pkg::IN_STEP]) begin
      if (trig.lvl[ahs_pkg::IN_UP]) begin
        position <= position + 32'h0000_0001;
      end else begin
        position <= position - 32'h0000_0001;
      end
    end
  end
endmodule

// >>> verilog/axis_homing_sequencer.sv
// Purpose: homing sequencer for a servo axis, methods 1 to 14 with index
// Assumes: 20 MHz clk, inputs asynchronous and synchronised here, Avalon-MM word-addressed slave
// Notes: velocity demand is the only motion output; ramp steps every 10 us
`timescale 1ns/100ps
module axis_homing_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic neg_limit,
  input wire logic pos_limit,
  input wire logic home_switch,
  input wire logic index_pulse,
  input wire logic enc_step,
  input wire logic enc_up,
  output logic signed [15:0] vel_demand,
  output logic home_attained,
  output logic target_reached,
  output logic homing_error
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEEK,
    ST_INDEX,
    ST_DONE,
    ST_ABORT,
    ST_ERROR
  } ahs_state_t;

  ahs_state_t state;
  ahs_pkg::ahs_mcfg_t cfg;
  ahs_pkg::ahs_mcfg_t sel;

  // software registers
  logic [15:0] ctrl_word;
  logic [7:0] method;
  logic [14:0] spd_switch;
  logic [14:0] spd_index;
  logic [14:0] accel;
  logic [31:0] home_offset;
  logic [2:0] halt_opt;

  // values captured at start
  logic [14:0] run_spd_switch;
  logic [14:0] run_spd_index;
  logic [14:0] run_accel;

  logic bus_req;
  logic bus_ack;
  logic wr_en;
  logic [31:0] rd_value;
  logic [31:0] wr_merged;
  logic [31:0] position;
  logic [15:0] status_word;

  logic start_bit;
  logic halt_bit;
  logic start_q;
  logic start_req;
  logic dir_right;
  logic lim_rev;
  logic moving_right;
  logic sw_edge;
  logic edge_is_b;
  logic lim_hit;
  logic home_load;
  logic running;
  logic vel_zero;
  logic [7:0] ramp_cnt;
  logic ramp_tick;
  logic signed [15:0] vel_target;
  logic signed [15:0] next_vel;
  logic signed [16:0] vel_diff;
  logic signed [16:0] acc_step;

  // byte-lane merge of a write into the current register value
  function automatic logic [31:0] ahs_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

  // method decode: trigger, sought edge, final and start directions
  function automatic ahs_pkg::ahs_mcfg_t ahs_method_cfg(input logic [7:0] m);
    ahs_pkg::ahs_mcfg_t c;
    c = '0;
    case (m)
      8'h01: c = '{1'b1, ahs_pkg::TRIG_NEG, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      8'h02: c = '{1'b1, ahs_pkg::TRIG_POS, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      8'h03: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      8'h04: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      8'h05: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      8'h06: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      8'h07: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      8'h08: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      8'h09: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      8'h0a: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      8'h0b: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      8'h0c: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      8'h0d: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      8'h0e: c = '{1'b1, ahs_pkg::TRIG_HOME, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      default: c = '0; // reserved and unsupported codes
    endcase
    return c;
  endfunction

  // four trigger inputs plus encoder step and direction
  ahs_trig_if trig ();

  ahs_input_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .raw_in({enc_up, enc_step, index_pulse, home_switch, pos_limit, neg_limit}),
    .trig(trig.sync)
  );

  ahs_pos_counter u_count (
    .clk(clk),
    .resetn(resetn),
    .trig(trig.cnt),
    .load(home_load),
    .load_value(home_offset),
    .position(position)
  );

  // bus handshake: one wait cycle, then the access completes
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign wr_en = avs_write & bus_ack;
  assign wr_merged = ahs_merge(rd_value, avs_writedata, avs_byteenable);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (avs_address)
      ahs_pkg::REG_CTRL: rd_value = {16'h0000, ctrl_word};
      ahs_pkg::REG_METHOD: rd_value = {24'h000000, method};
      ahs_pkg::REG_SPD_SWITCH: rd_value = {17'h00000, spd_switch};
      ahs_pkg::REG_SPD_INDEX: rd_value = {17'h00000, spd_index};
      ahs_pkg::REG_ACCEL: rd_value = {17'h00000, accel};
      ahs_pkg::REG_OFFSET: rd_value = home_offset;
      ahs_pkg::REG_HALT_OPT: rd_value = {29'h00000000, halt_opt};
      ahs_pkg::REG_STATUS: rd_value = {16'h0000, status_word};
      ahs_pkg::REG_POSITION: rd_value = position;
      ahs_pkg::REG_VELOCITY: rd_value = {{16{vel_demand[15]}}, vel_demand};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= '0;
    end else if (avs_read & ~bus_ack) begin
      avs_readdata <= rd_value;
    end
  end

  // writable registers; writes to read-only or unmapped words are dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_word <= ahs_pkg::CTRL_RST;
      method <= ahs_pkg::METHOD_RST;
      spd_switch <= ahs_pkg::SPD_SWITCH_RST;
      spd_index <= ahs_pkg::SPD_INDEX_RST;
      accel <= ahs_pkg::ACCEL_RST;
      home_offset <= ahs_pkg::OFFSET_RST;
      halt_opt <= ahs_pkg::HALT_OPT_RST;
    end else if (wr_en) begin
      case (avs_address)
        ahs_pkg::REG_CTRL: ctrl_word <= wr_merged[15:0];
        ahs_pkg::REG_METHOD: method <= wr_merged[7:0];
        ahs_pkg::REG_SPD_SWITCH: spd_switch <= wr_merged[14:0];
        ahs_pkg::REG_SPD_INDEX: spd_index <= wr_merged[14:0];
        ahs_pkg::REG_ACCEL: accel <= wr_merged[14:0];
        ahs_pkg::REG_OFFSET: home_offset <= wr_merged;
        ahs_pkg::REG_HALT_OPT: halt_opt <= wr_merged[2:0];
        default: ;
      endcase
    end
  end

  // start is the rising edge of bit 4, honoured only with halt clear
  assign start_bit = ctrl_word[ahs_pkg::CW_START_BIT];
  assign halt_bit = ctrl_word[ahs_pkg::CW_HALT_BIT];
  assign start_req = start_bit & ~start_q & ~halt_bit;
  assign sel = ahs_method_cfg(method);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_q <= 1'b0;
    end else if (!halt_bit) begin
      start_q <= start_bit; // a start held across a halt fires on release
    end
  end

  // actual travel direction; commanded one while at standstill
  assign vel_zero = (vel_demand == 16'sh0000);
  assign moving_right = vel_zero ? dir_right : ~vel_demand[15];

  // an edge is type b when seen moving right falling or left rising
  assign sw_edge = trig.rise[cfg.trig] | trig.fall[cfg.trig];
  assign edge_is_b = (moving_right == trig.fall[cfg.trig]);
  assign lim_hit = cfg.lim_rev_en &
                   (moving_right ? trig.rise[ahs_pkg::IN_POS] : trig.rise[ahs_pkg::IN_NEG]);
  assign running = (state == ST_SEEK) || (state == ST_INDEX);
  assign home_load = (state == ST_INDEX) & start_bit & ~halt_bit &
                     trig.rise[ahs_pkg::IN_INDEX];

  // homing sequence; edges are ignored while halted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cfg <= '0;
      dir_right <= 1'b0;
      lim_rev <= 1'b0;
      run_spd_switch <= '0;
      run_spd_index <= '0;
      run_accel <= '0;
    end else begin
      case (state)
        ST_IDLE, ST_DONE, ST_ABORT, ST_ERROR: begin
          if (start_req) begin
            if (!sel.valid) begin
              state <= ST_ERROR;
            end else begin
              cfg <= sel;
              lim_rev <= 1'b0;
              run_spd_switch <= spd_switch;
              run_spd_index <= spd_index;
              run_accel <= accel;
              dir_right <= trig.lvl[sel.trig] ? sel.high_right : sel.low_right;
              state <= ST_SEEK;
            end
          end
        end
        ST_SEEK: begin
          if (!start_bit) begin
            state <= ST_ABORT;
          end else if (!halt_bit) begin
            if (sw_edge && edge_is_b == cfg.edge_b) begin
              if (moving_right == cfg.final_right) begin
                state <= ST_INDEX;
              end else begin
                dir_right <= ~moving_right;
              end
            end else if (lim_hit) begin
              if (lim_rev) begin
                state <= ST_ERROR; // both limits met, switch never found
              end else begin
                lim_rev <= 1'b1;
                dir_right <= ~moving_right;
              end
            end
          end
        end
        ST_INDEX: begin
          if (!start_bit) begin
            state <= ST_ABORT;
          end else if (home_load) begin
            state <= ST_DONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // target velocity: fast toward the switch, slow toward the index
  always_comb begin
    vel_target = 16'sh0000;
    if (running && !halt_bit) begin
      if (state == ST_SEEK) begin
        vel_target = dir_right ? $signed({1'b0, run_spd_switch})
                               : -$signed({1'b0, run_spd_switch});
      end else begin
        vel_target = dir_right ? $signed({1'b0, run_spd_index})
                               : -$signed({1'b0, run_spd_index});
      end
    end
  end

  // ramp one acceleration step toward the target
  always_comb begin
    acc_step = $signed({2'b00, run_accel});
    vel_diff = 17'(vel_target) - 17'(vel_demand);
    if (vel_diff > acc_step) begin
      next_vel = 16'(17'(vel_demand) + acc_step);
    end else if (vel_diff < -acc_step) begin
      next_vel = 16'(17'(vel_demand) - acc_step);
    end else begin
      next_vel = vel_target;
    end
  end

  // ramp period prescaler
  assign ramp_tick = (ramp_cnt == ahs_pkg::RAMP_LAST);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ramp_cnt <= '0;
    end else if (ramp_tick) begin
      ramp_cnt <= '0;
    end else begin
      ramp_cnt <= ramp_cnt + 8'h01;
    end
  end

  // velocity demand to the position loops; errors and non-ramp halts stop dead
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vel_demand <= 16'sh0000;
    end else if (state == ST_ERROR) begin
      vel_demand <= 16'sh0000;
    end else if (halt_bit && halt_opt != ahs_pkg::HALT_OPT_RAMP) begin
      vel_demand <= 16'sh0000;
    end else if (ramp_tick) begin
      vel_demand <= next_vel; // ramp option uses the homing acceleration
    end
  end

  // statusword: bit 12 homed, bit 10 target reached, bit 13 error
  always_comb begin
    status_word = 16'h0000;
    case (state)
      ST_IDLE, ST_ABORT: status_word[ahs_pkg::SW_REACHED_BIT] = 1'b1;
      ST_SEEK, ST_INDEX: status_word[ahs_pkg::SW_REACHED_BIT] = halt_bit & vel_zero;
      ST_DONE: begin
        status_word[ahs_pkg::SW_ATTAINED_BIT] = 1'b1;
        status_word[ahs_pkg::SW_REACHED_BIT] = vel_zero;
      end
      ST_ERROR: begin
        status_word[ahs_pkg::SW_ERROR_BIT] = 1'b1;
        status_word[ahs_pkg::SW_REACHED_BIT] = vel_zero;
      end
      default: status_word = 16'h0000;
    endcase
  end

  // registered status pins, one cycle behind the status register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      home_attained <= 1'b0;
      target_reached <= 1'b1;
      homing_error <= 1'b0;
    end else begin
      home_attained <= status_word[ahs_pkg::SW_ATTAINED_BIT];
      target_reached <= status_word[ahs_pkg::SW_REACHED_BIT];
      homing_error <= status_word[ahs_pkg::SW_ERROR_BIT];
    end
  end
endmodule

// >>> tb/ahs_axis_model.sv
// Purpose: axis model driving encoder, limits, home switch and index
// Assumes: 4096 demand units per count, one count per step pulse
// Notes: kind 0/1 half-travel switch, 2/3 zone switch
`timescale 1ns/100ps
module ahs_axis_model (
  input wire logic clk,
  input wire logic rewind,
  input wire logic [1:0] sw_kind,
  input wire logic signed [15:0] vel_demand,
  output logic neg_limit,
  output logic pos_limit,
  output logic home_switch,
  output logic index_pulse,
  output logic enc_step,
  output logic enc_up,
  output logic signed [31:0] count
);
  logic signed [31:0] fine;
  logic signed [31:0] last;
  // start at the origin, direction up
  initial begin
    fine = 32'sh0;
    last = 32'sh0;
    enc_step = 1'b0;
    enc_up = 1'b1;
    index_pulse = 1'b0;
  end
  // integrate demand; count rises toward maximum
  always @(posedge clk) begin
    fine <= rewind ? 32'sh0 : fine + 32'(vel_demand);
    last <= count;
    enc_step <= count != last;
    enc_up <= (count == last) ? enc_up : count > last;
    index_pulse <= count[4:0] == 5'h0; // same edge as the step pulse
  end
  assign count = fine >>> 12;
  // limits beyond 80 counts on either side
  assign neg_limit = count < -32'sh50;
  assign pos_limit = count > 32'sh50;
  // switch shape by kind; kind 3 starts inside its zone
  always_comb begin
    case (sw_kind)
      2'h0: home_switch = count >= 32'sh14;
      2'h1: home_switch = count <= 32'sh14;
      2'h2: home_switch = count >= 32'sh14 && count <= 32'sh32;
      default: home_switch = count >= -32'sha && count <= 32'sh28;
    endcase
  end
endmodule

// >>> tb/ahs_checker.sv
// Purpose: port assertions for the homing sequencer
// Assumes: one clock, resetn asynchronous active low
// Notes: bound to every sequencer instance
`timescale 1ns/100ps
module ahs_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic signed [15:0] vel_demand,
  input wire logic home_attained,
  input wire logic target_reached,
  input wire logic homing_error
);
  logic req;
  assign req = avs_read | avs_write;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // a fresh request waits exactly once
  sequence s_req_new;
    req && !$past(req);
  endsequence
  sequence s_wait_once;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_wait_first: assert property (s_req_new |-> s_wait_once) else $error("bad wait state");
  a_wait_idle: assert property (!req |-> !avs_waitrequest) else $error("wait without request");
  a_rd_unmapped: assert property (avs_read && !avs_waitrequest && avs_address > 4'h9
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_reset_idle: assert property ($rose(resetn) |-> target_reached && !home_attained
    && vel_demand == 16'sh0) else $error("bad state after reset");
  a_done_still: assert property (home_attained && target_reached |-> vel_demand == 16'sh0)
    else $error("done while moving");
  a_err_no_home: assert property (homing_error |-> !home_attained)
    else $error("error with home attained");
  a_err_still: assert property (homing_error && $past(homing_error)
    |-> vel_demand == 16'sh0) else $error("moving in error");
  a_vel_hold: assert property ($changed(vel_demand) |=> $stable(vel_demand) [*8])
    else $error("demand changed too soon");
endmodule
bind axis_homing_sequencer ahs_checker chk_u (
  .clk(clk),
  .resetn(resetn),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .vel_demand(vel_demand),
  .home_attained(home_attained),
  .target_reached(target_reached),
  .homing_error(homing_error)
);

// >>> tb/tb.sv
// Purpose: self-checking bench for the homing sequencer
// Assumes: axis model at count 0 before each run
// Notes: home index expected per method and switch shape
`timescale 1ns/100ps
module tb;
  typedef struct {logic [7:0] m; logic [1:0] k; logic signed [31:0] idx;} ahs_row_t;
  logic clk, resetn, avs_read, avs_write, rewind, avs_waitrequest;
  logic neg_limit, pos_limit, home_switch, index_pulse, enc_step, enc_up;
  logic home_attained, target_reached, homing_error;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic signed [15:0] vel_demand;
  logic signed [31:0] count;
  logic [1:0] sw_kind;
  int fails, checks_done;
  // method, switch kind, index expected as home
  ahs_row_t rows [16] = '{'{8'h01, 2'h0, -32'sh40}, '{8'h02, 2'h0, 32'sh40},
    '{8'h03, 2'h0, 32'sh0}, '{8'h04, 2'h0, 32'sh20}, '{8'h05, 2'h1, 32'sh20},
    '{8'h06, 2'h1, 32'sh0}, '{8'h07, 2'h2, 32'sh0}, '{8'h08, 2'h2, 32'sh20},
    '{8'h09, 2'h2, 32'sh20}, '{8'h0a, 2'h2, 32'sh40}, '{8'h0b, 2'h2, 32'sh40},
    '{8'h0c, 2'h2, 32'sh20}, '{8'h0d, 2'h2, 32'sh20}, '{8'h0e, 2'h2, 32'sh0},
    '{8'h08, 2'h3, 32'sh0}, '{8'h0a, 2'h3, 32'sh40}};
  logic [7:0] bad [3] = '{8'h00, 8'h0f, 8'h10};
  logic [3:0] ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h100, 32'h10, 32'h10, 32'h0, 32'h1, 32'h0};
  axis_homing_sequencer dut_u (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .neg_limit(neg_limit), .pos_limit(pos_limit),
    .home_switch(home_switch), .index_pulse(index_pulse), .enc_step(enc_step),
    .enc_up(enc_up), .vel_demand(vel_demand), .home_attained(home_attained),
    .target_reached(target_reached), .homing_error(homing_error));
  ahs_axis_model axis_u (.clk(clk), .rewind(rewind), .sw_kind(sw_kind),
    .vel_demand(vel_demand), .neg_limit(neg_limit), .pos_limit(pos_limit),
    .home_switch(home_switch), .index_pulse(index_pulse), .enc_step(enc_step),
    .enc_up(enc_up), .count(count));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      end_sim();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // bounded wait for done, or for motion
  task await(input logic done);
    int n;
    n = 0;
    while (n < 20000 && (done ? !(home_attained === 1'b1 && target_reached === 1'b1)
        : vel_demand === 16'sh0)) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      end_sim();
    end
  endtask
  task home_run(input logic [7:0] m, input logic [1:0] k);
    sw_kind <= k;
    bus(1'b1, ahs_pkg::REG_CTRL, 32'h0);
    bus(1'b1, ahs_pkg::REG_METHOD, {24'h0, m});
    rewind <= 1'b1;
    @(posedge clk);
    rewind <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, ahs_pkg::REG_CTRL, 32'h10);
    repeat (2) @(posedge clk);
  endtask
  task check_home(input logic [31:0] off, input logic signed [31:0] idx);
    await(1'b1);
    repeat (8) @(posedge clk);
    bus(1'b0, ahs_pkg::REG_POSITION, 32'h0);
    chk(q, off + 32'(count - idx));
    bus(1'b0, ahs_pkg::REG_STATUS, 32'h0);
    chk(q & 32'h3400, 32'h1400);
  endtask
  initial begin
    {avs_read, avs_write, rewind, resetn} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    sw_kind = 2'h0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b1, ahs_pkg::REG_SPD_SWITCH, 32'h100);
    bus(1'b1, ahs_pkg::REG_SPD_INDEX, 32'h80);
    bus(1'b1, ahs_pkg::REG_ACCEL, 32'h80);
    foreach (rows[i]) begin
      bus(1'b1, ahs_pkg::REG_OFFSET, 32'h100 + 32'(i));
      home_run(rows[i].m, rows[i].k);
      check_home(32'h100 + 32'(i), rows[i].idx);
    end
    // halt with ramp, then immediate, then resume
    for (int h = 1; h <= 2; h++) begin
      bus(1'b1, ahs_pkg::REG_HALT_OPT, 32'(h));
      home_run(8'h08, 2'h2);
      await(1'b0);
      repeat (8) @(posedge clk); // keep the halt clear of the last ramp step
      bus(1'b1, ahs_pkg::REG_CTRL, 32'h110);
      repeat (h == 1 ? 600 : 4) @(posedge clk);
      chk(32'(vel_demand), 32'h0);
      bus(1'b1, ahs_pkg::REG_CTRL, 32'h10);
      check_home(32'h10f, 32'sh20);
    end
    // withdraw start while seeking
    home_run(8'h0b, 2'h2);
    await(1'b0);
    bus(1'b1, ahs_pkg::REG_CTRL, 32'h0);
    repeat (600) @(posedge clk);
    chk({14'h0, home_attained, target_reached, vel_demand}, 32'h0001_0000);
    // reserved and invalid codes run nothing
    foreach (bad[j]) begin
      home_run(bad[j], 2'h0);
      repeat (8) @(posedge clk);
      chk({15'h0, homing_error, vel_demand}, 32'h0001_0000);
      bus(1'b0, ahs_pkg::REG_STATUS, 32'h0);
      chk(q & 32'h3000, 32'h2000);
    end
    // reset in mid-run stops at once
    home_run(8'h07, 2'h2);
    await(1'b0);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({14'h0, home_attained, target_reached, vel_demand}, 32'h0001_0000);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (ra[k]) begin
      bus(1'b0, ra[k], 32'h0);
      chk(q, rv[k]);
    end
    bus(1'b1, ahs_pkg::REG_STATUS, 32'hffff_ffff);
    bus(1'b0, ahs_pkg::REG_STATUS, 32'h0);
    chk(q & 32'h3400, 32'h0400);
    end_sim();
  end
endmodule
